// File: i2csl_consts.vh
// constants for the two-wire slave port: offsets, fields, reset values
`ifndef I2CSL_CONSTS_VH
`define I2CSL_CONSTS_VH

// register word addresses (byte address = index * 4)
`define I2CSL_IDX_CTRL 3'h0
`define I2CSL_IDX_STAT 3'h1
`define I2CSL_IDX_ADDR 3'h2
`define I2CSL_IDX_TX 3'h3
`define I2CSL_IDX_RX 3'h4

// control fields
`define I2CSL_CTL_EN 15
`define I2CSL_CTL_CLKREL 12
`define I2CSL_CTL_WIDE 10
`define I2CSL_CTL_STRETCH_ENABLE 6

// status fields (bits 5..0 read-only)
`define I2CSL_ST_OV 6
`define I2CSL_ST_WIDE_OK 5
`define I2CSL_ST_RW 4
`define I2CSL_ST_ADDRFLAG 3
`define I2CSL_ST_RBF 1
`define I2CSL_ST_TBF 0
`define I2CSL_ST_EVENT 7

// reset values
`define I2CSL_CTRL_RST 16'h1000
`define I2CSL_STAT_RST 16'h0000
`define I2CSL_ADDR_RST 10'h000

// fixed upper pattern of a wide-address first byte
`define I2CSL_WIDE_HDR 5'h1E

`endif

// File: i2csl_sync.v
// two-stage synchroniser with edge detection for one bus line
`timescale 1ns/1ns
module i2csl_sync (
	input wire mclk,
	input wire rst,
	input wire din,
	output reg level_q,
	output wire rise,
	output wire fall
);
	reg meta_q;
	reg sync_q;

	// lines idle high, so reset to high to avoid a false edge
	always @(posedge mclk) begin
		if (rst) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			level_q <= 1'b1;
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
			level_q <= sync_q;
		end
	end

	assign rise = sync_q & ~level_q;
	assign fall = ~sync_q & level_q;
endmodule // i2csl_sync

// File: i2csl_top.v
// two-wire bus slave: address match, receive buffer, transmit, stretching
//
// Summary of operation
// - idle until start, then shift address byte
// - narrow mode: address bits 6:0 vs shift 7:1
// - control bit 10 selects ten-bit addressing
// - sample data on clock rising edge
// - address match: ack, event flag, buffer untouched
// - read direction: ack, stretch, shift out byte
// - transmit data changes on clock falling edge
// - transmit event at ninth fall regardless ack
// - receive: load buffer if not full, ack
// - buffer full: no ack, event, no load
// - overflow set, buffer empty: load, nack
// - receive and transmit both double-buffered
// - wide first byte 11110 plus bits 9:8
// - wide first byte mismatch, or read without a prior match: idle
// - wide second byte vs bits 7:0
// - after restart only first byte must match
// - transmit stretch when buffer empty, any stretch enable
// - ack and empty buffer: clear release
// - buffer loaded early: no stretch
// - release set works whatever buffer state
// - control rw; status low six read-only
// - receive stretch when full and enabled
// - release writes ignored when stretch disabled, except a release set in transmit state
`timescale 1ns/1ns
`include "i2csl_consts.vh"
module i2csl_top (
	input wire mclk,
	input wire rst,
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire scl_in,
	output reg scl_out,
	output reg scl_oe,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe
);
	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_ADDR = 3'd1;
	localparam [2:0] ST_ADDR2 = 3'd2;
	localparam [2:0] ST_RX = 3'd3;
	localparam [2:0] ST_TX = 3'd4;
	localparam [2:0] ST_ACK = 3'd5;
	localparam [2:0] ST_TXACK = 3'd6;

	wire scl_s;
	wire scl_rise;
	wire scl_fall;
	wire sda_s;
	wire sda_rise;
	wire sda_fall;

	i2csl_sync u_scl (
		.mclk(mclk),
		.rst(rst),
		.din(scl_in),
		.level_q(scl_s),
		.rise(scl_rise),
		.fall(scl_fall)
	);

	i2csl_sync u_sda (
		.mclk(mclk),
		.rst(rst),
		.din(sda_in),
		.level_q(sda_s),
		.rise(sda_rise),
		.fall(sda_fall)
	);

	reg [15:0] ctrl_q;
	reg [15:0] stat_q;
	reg [9:0] addr_q;
	reg [7:0] tx_q;
	reg [7:0] rx_q;
	reg [7:0] shift_q;
	reg [3:0] bitcnt_q;
	reg [2:0] state_q;
	reg [2:0] after_ack_q;
	reg ack_drive_q;
	reg prior_match_q;
	reg first_wide_q;
	reg ninth_rx_q;
	reg [7:0] tx_shift_q;

	wire enable = ctrl_q[`I2CSL_CTL_EN];
	wire wide = ctrl_q[`I2CSL_CTL_WIDE];
	wire stretch_enable = ctrl_q[`I2CSL_CTL_STRETCH_ENABLE];
	wire release_bit = ctrl_q[`I2CSL_CTL_CLKREL];
	// start/stop: data moves while clock high
	wire start_det = sda_fall & scl_s;
	wire stop_det = sda_rise & scl_s;

	// ----------------------------------------------------------------
	// bus access
	// ----------------------------------------------------------------
	// one wait cycle per access: answer on second edge of a request
	wire acc = (avs_read | avs_write) & avs_waitrequest;
	wire wr = avs_write & ~avs_waitrequest;
	wire rd_rx = avs_read & ~avs_waitrequest &
		(avs_address[4:2] == `I2CSL_IDX_RX);
	wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire wr_ctrl = wr & (avs_address[4:2] == `I2CSL_IDX_CTRL);
	wire wr_stat = wr & (avs_address[4:2] == `I2CSL_IDX_STAT);
	wire wr_addr = wr & (avs_address[4:2] == `I2CSL_IDX_ADDR);
	wire wr_tx = wr & (avs_address[4:2] == `I2CSL_IDX_TX) &
		avs_byteenable[0];

	always @(posedge mclk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else begin
			avs_waitrequest <= ~acc;
			if (acc & avs_read) begin
				case (avs_address[4:2])
				`I2CSL_IDX_CTRL: avs_readdata <= {16'h0000, ctrl_q};
				`I2CSL_IDX_STAT: avs_readdata <= {16'h0000, stat_q};
				`I2CSL_IDX_ADDR: avs_readdata <= {22'h00000, addr_q};
				`I2CSL_IDX_TX: avs_readdata <= {24'h000000, tx_q};
				`I2CSL_IDX_RX: avs_readdata <= {24'h000000, rx_q};
				default: avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// protocol engine and registers
	// ----------------------------------------------------------------
	wire [15:0] ctrl_wdata = (ctrl_q & ~be_mask) |
		(avs_writedata[15:0] & be_mask);
	wire narrow_hit = (shift_q[7:1] == addr_q[6:0]);
	wire wide_hdr_hit = (shift_q[7:3] == `I2CSL_WIDE_HDR) &
		(shift_q[2:1] == addr_q[9:8]);
	wire rx_buffer_full = stat_q[`I2CSL_ST_RBF];
	wire ov = stat_q[`I2CSL_ST_OV];
	wire tx_buffer_full = stat_q[`I2CSL_ST_TBF];

	always @(posedge mclk) begin
		if (rst) begin
			ctrl_q <= `I2CSL_CTRL_RST;
			stat_q <= `I2CSL_STAT_RST;
			addr_q <= `I2CSL_ADDR_RST;
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			shift_q <= 8'h00;
			tx_shift_q <= 8'h00;
			bitcnt_q <= 4'h0;
			state_q <= ST_IDLE;
			after_ack_q <= ST_IDLE;
			ack_drive_q <= 1'b0;
			prior_match_q <= 1'b0;
			first_wide_q <= 1'b0;
			ninth_rx_q <= 1'b0;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			scl_out <= 1'b0;
			scl_oe <= 1'b0;
		end else begin
			// software side; hardware events below override
			if (wr_ctrl) begin
				ctrl_q <= ctrl_wdata;
				// release writes only honoured with stretch enabled; a set is also taken in transmit state (below)
				if (!stretch_enable)
					ctrl_q[`I2CSL_CTL_CLKREL] <= release_bit;
			end
			if (wr_stat) begin
				stat_q[15:6] <= (stat_q[15:6] & ~be_mask[15:6]) |
					(avs_writedata[15:6] & be_mask[15:6]);
			end
			if (wr_addr)
				addr_q <= avs_writedata[9:0];
			if (wr_tx) begin
				tx_q <= avs_writedata[7:0];
				stat_q[`I2CSL_ST_TBF] <= 1'b1;
			end
			if (rd_rx)
				stat_q[`I2CSL_ST_RBF] <= 1'b0;

			if (!enable) begin
				state_q <= ST_IDLE;
				sda_oe <= 1'b0;
				scl_oe <= 1'b0;
			end else if (stop_det) begin
				state_q <= ST_IDLE;
				sda_oe <= 1'b0;
				prior_match_q <= 1'b0;
			end else if (start_det) begin
				state_q <= ST_ADDR;
				bitcnt_q <= 4'h0;
				sda_oe <= 1'b0;
				first_wide_q <= 1'b1;
			end else begin
				case (state_q)
				ST_IDLE: begin
					sda_oe <= 1'b0;
				end
				ST_ADDR, ST_ADDR2, ST_RX: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_s};
						bitcnt_q <= bitcnt_q + 4'h1;
					end
					if (scl_fall && bitcnt_q == 4'h8) begin
						bitcnt_q <= 4'h0;
						ack_drive_q <= 1'b0;
						state_q <= ST_IDLE;
						if (state_q == ST_RX) begin
							state_q <= ST_ACK;
							after_ack_q <= ST_RX;
							ninth_rx_q <= 1'b1;
							if (!rx_buffer_full) begin
								rx_q <= shift_q;
								stat_q[`I2CSL_ST_RBF] <= 1'b1;
								ack_drive_q <= ~ov;
							end else begin
								stat_q[`I2CSL_ST_OV] <= 1'b1;
							end
						end else if (state_q == ST_ADDR2) begin
							ninth_rx_q <= 1'b0;
							if (shift_q == addr_q[7:0]) begin
								stat_q[`I2CSL_ST_WIDE_OK] <= 1'b1;
								prior_match_q <= 1'b1;
								ack_drive_q <= 1'b1;
								state_q <= ST_ACK;
								after_ack_q <= ST_RX;
							end else begin
								stat_q[`I2CSL_ST_WIDE_OK] <= 1'b0;
							end
						end else if (!wide) begin
							ninth_rx_q <= 1'b0;
							if (narrow_hit) begin
								ack_drive_q <= 1'b1;
								state_q <= ST_ACK;
								stat_q[`I2CSL_ST_RW] <= shift_q[0];
								after_ack_q <= shift_q[0] ? ST_TX : ST_RX;
							end
						end else begin
							ninth_rx_q <= 1'b0;
							if (wide_hdr_hit && shift_q[0] &&
								prior_match_q) begin
								ack_drive_q <= 1'b1;
								state_q <= ST_ACK;
								stat_q[`I2CSL_ST_RW] <= 1'b1;
								after_ack_q <= ST_TX;
							end else if (wide_hdr_hit && !shift_q[0]) begin
								stat_q[`I2CSL_ST_WIDE_OK] <= 1'b0;
								stat_q[`I2CSL_ST_RW] <= 1'b0;
								ack_drive_q <= 1'b1;
								state_q <= ST_ACK;
								after_ack_q <= ST_ADDR2;
							end else begin
								stat_q[`I2CSL_ST_WIDE_OK] <= 1'b0;
								prior_match_q <= 1'b0;
							end
						end
					end
				end
				ST_ACK: begin
					// ack driven low during the ninth clock
					sda_oe <= ack_drive_q;
					sda_out <= 1'b0;
					if (scl_fall && bitcnt_q == 4'h1) begin
						// end of ninth clock: event and stretch decisions
						sda_oe <= 1'b0;
						bitcnt_q <= 4'h0;
						stat_q[`I2CSL_ST_EVENT] <= 1'b1;
						state_q <= after_ack_q;
						if (after_ack_q == ST_TX) begin
							if (!tx_buffer_full)
								ctrl_q[`I2CSL_CTL_CLKREL] <= 1'b0;
							tx_shift_q <= tx_q;
						end else if (ninth_rx_q && stretch_enable &&
							stat_q[`I2CSL_ST_RBF]) begin
							ctrl_q[`I2CSL_CTL_CLKREL] <= 1'b0;
						end
					end else if (scl_rise) begin
						bitcnt_q <= 4'h1;
					end
				end
				ST_TX: begin
					// data moves only while the clock is held/low
					if (tx_buffer_full && release_bit && bitcnt_q == 4'h0 &&
						!scl_s) begin
						tx_shift_q <= tx_q;
					end
					if (scl_fall || (bitcnt_q == 4'h0 && !scl_s &&
						release_bit)) begin
						if (bitcnt_q == 4'h0 && !sda_oe && !scl_fall) begin
							// shifter may still hold the old byte here
							sda_oe <= ~tx_q[7];
							tx_shift_q <= tx_q;
							stat_q[`I2CSL_ST_TBF] <= 1'b0;
							bitcnt_q <= 4'h1;
						end else if (scl_fall && bitcnt_q < 4'h8 &&
							bitcnt_q != 4'h0) begin
							sda_oe <= ~tx_shift_q[7 - bitcnt_q[2:0]];
							bitcnt_q <= bitcnt_q + 4'h1;
						end else if (scl_fall && bitcnt_q == 4'h8) begin
							sda_oe <= 1'b0;
							bitcnt_q <= 4'h0;
							state_q <= ST_TXACK;
						end
					end
				end
				ST_TXACK: begin
					if (scl_rise)
						shift_q[0] <= sda_s;
					if (scl_fall) begin
						stat_q[`I2CSL_ST_EVENT] <= 1'b1;
						if (!shift_q[0]) begin
							state_q <= ST_TX;
							tx_shift_q <= tx_q;
							if (!tx_buffer_full)
								ctrl_q[`I2CSL_CTL_CLKREL] <= 1'b0;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				default: state_q <= ST_IDLE;
				endcase
			end

			// set by software wins; stretch only while clock is low
			if (wr_ctrl && stretch_enable && ctrl_wdata[`I2CSL_CTL_CLKREL])
				ctrl_q[`I2CSL_CTL_CLKREL] <= 1'b1;
			if (wr_ctrl && state_q == ST_TX && ctrl_wdata[`I2CSL_CTL_CLKREL])
				ctrl_q[`I2CSL_CTL_CLKREL] <= 1'b1;
			scl_out <= 1'b0;
			scl_oe <= enable & ~release_bit & ~scl_s;
		end
	end
endmodule // i2csl_top

// File: i2csl_props.sv
// checker of the slave port's pins and register handshake
`timescale 1ns/1ns
module i2csl_props (
	input wire mclk,
	input wire rst,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire scl_in,
	input wire scl_out,
	input wire scl_oe,
	input wire sda_out,
	input wire sda_oe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	a_scl_pull_only: assert property (scl_oe |-> !scl_out)
		else $error("clock line driven high");
	a_sda_pull_only: assert property (sda_oe |-> !sda_out)
		else $error("data line driven high");
	a_idle_after_reset: assert property ($fell(rst) |->
		!scl_oe && !sda_oe && avs_waitrequest)
		else $error("lines or bus busy after reset");
	a_req_answered: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered next cycle");
	a_wait_one_cycle: assert property (!avs_waitrequest |=>
		avs_waitrequest)
		else $error("waitrequest low too long");
	a_upper_half_zero: assert property (avs_read &&
		!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_stretch_on_low: assert property ($rose(scl_oe) |->
		!$past(scl_in))
		else $error("stretch began while clock high");
	a_data_moves_low: assert property (!$stable(sda_oe) |->
		!scl_in)
		else $error("data changed while clock high");
	c_stretch: cover property ($rose(scl_oe));
	c_ack: cover property ($rose(sda_oe));
	c_read: cover property (avs_read && !avs_waitrequest);
endmodule // i2csl_props
bind i2csl_top i2csl_props u_props (.mclk(mclk), .rst(rst),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
	.sda_out(sda_out), .sda_oe(sda_oe));

// File: i2csl_master_model.sv
// behavioural bus master pulling both lines open-drain
`timescale 1ns/1ns
module i2csl_master_model (
	input wire scl_line,
	input wire sda_line,
	output reg scl_pull,
	output reg sda_pull
);
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	// slave may stretch: wait (bounded) for the line to really rise
	task clk_bit(input b, output r);
		integer n;
		begin
			#10 sda_pull = ~b;
			#90 scl_pull = 1'b0;
			n = 0;
			while (scl_line !== 1'b1 && n < 5000) begin
				#20 n = n + 1;
			end
			#60 r = sda_line;
			scl_pull = 1'b1;
		end
	endtask
	// also a repeated start: free both lines before pulling data low
	task start;
		begin
			#10 sda_pull = 1'b0;
			#90 scl_pull = 1'b0;
			#80 sda_pull = 1'b1;
			#80 scl_pull = 1'b1;
		end
	endtask
	task stop;
		begin
			#10 sda_pull = 1'b1;
			#90 scl_pull = 1'b0;
			#80 sda_pull = 1'b0;
			#80;
		end
	endtask
	task xfer(input [7:0] d, input am, output [7:0] q, output ak);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1)
				clk_bit(d[i], q[i]);
			clk_bit(am, ak);
		end
	endtask
endmodule // i2csl_master_model

// File: testbench.sv
// self-checking bench of the two-wire slave port
`timescale 1ns/1ns
module testbench;
	reg mclk, rst, avs_read, avs_write, ak;
	reg [4:0] avs_address;
	reg [31:0] avs_writedata, seed, cycles;
	reg [6:0] a;
	reg [7:0] d1, d2, q;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, scl_out, scl_oe, sda_out, sda_oe, m_scl, m_sda;
	wire scl_line = ~(scl_oe | m_scl);
	wire sda_line = ~(sda_oe | m_sda);
	integer fail_count, compares;
	reg [31:0] expq[$];
	i2csl_top dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe));
	i2csl_master_model m (.scl_line(scl_line), .sda_line(sda_line),
		.scl_pull(m_scl), .sda_pull(m_sda));
	always #10 mclk = ~mclk;
	task chk_rd(input [31:0] g, input [31:0] e);
		begin
			compares = compares + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("FAIL t=%0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task chk_link(input [7:0] g, input [7:0] e);
		begin
			compares = compares + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("FAIL t=%0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task bus(input wr, input [4:0] ad, input [15:0] d, input [15:0] e);
		integer n;
		begin
			@(posedge mclk);
			avs_address <= ad;
			avs_write <= wr;
			avs_read <= ~wr;
			avs_writedata <= {16'h0000, d};
			if (!wr)
				expq.push_back({16'h0000, e});
			n = 0;
			do begin
				@(posedge mclk);
				n = n + 1;
			end while (avs_waitrequest !== 1'b0 && n < 100);
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask
	always @(posedge mclk)
		if (avs_read && avs_waitrequest === 1'b0)
			chk_rd(avs_readdata, expq.pop_front());
	task finish_test;
		begin
			$display("compares %0d fails %0d", compares, fail_count);
			if (fail_count == 0 && compares > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	always @(posedge mclk) begin
		cycles = cycles + 1;
		if (cycles == 32'd30000) begin
			fail_count = fail_count + 1;
			finish_test;
		end
	end
	initial begin
		mclk = 0; rst = 1; avs_read = 0; avs_write = 0; avs_address = 0;
		avs_writedata = 0; cycles = 0; fail_count = 0; compares = 0;
		seed = 32'h9148;
		a = 7'h08 + 7'({$random(seed)} % 112);
		d1 = 8'($random(seed));
		d2 = 8'($random(seed));
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		bus(0, 5'h00, 0, 16'h1000);
		bus(0, 5'h04, 0, 16'h0000);
		bus(0, 5'h08, 0, 16'h0000);
		bus(0, 5'h1C, 0, 16'h0000);
		bus(1, 5'h04, 16'h003F, 0);
		bus(0, 5'h04, 0, 16'h0000);
		bus(1, 5'h00, 16'h8000, 0);
		bus(0, 5'h00, 0, 16'h9000);
		bus(1, 5'h08, {9'h000, a}, 0);
		$display("registers done");
		m.start;
		m.xfer({a, 1'b0}, 1'b1, q, ak);
		chk_link({7'h00, ak}, 8'h00);
		m.xfer(d1, 1'b1, q, ak);
		chk_link({7'h00, ak}, 8'h00);
		m.xfer(d2, 1'b1, q, ak);
		chk_link({7'h00, ak}, 8'h01);
		m.stop;
		bus(0, 5'h04, 0, 16'h00C2);
		bus(0, 5'h10, 0, {8'h00, d1});
		bus(1, 5'h04, 16'h0000, 0);
		m.start;
		m.xfer({a ^ 7'h01, 1'b0}, 1'b1, q, ak);
		chk_link({7'h00, ak}, 8'h01);
		m.stop;
		$display("receive done");
		m.start;
		m.xfer({a, 1'b1}, 1'b1, q, ak);
		chk_link({7'h00, ak}, 8'h00);
		repeat (30) @(posedge mclk);
		chk_link({7'h00, scl_oe}, 8'h01);
		bus(1, 5'h0C, {8'h00, d2}, 0);
		bus(1, 5'h00, 16'h9000, 0);
		m.xfer(8'hFF, 1'b0, q, ak);
		chk_link(q, d2);
		repeat (30) @(posedge mclk);
		chk_link({7'h00, scl_oe}, 8'h01);
		bus(1, 5'h0C, {8'h00, d1}, 0);
		bus(1, 5'h00, 16'h9000, 0);
		bus(1, 5'h04, 16'h0000, 0);
		m.xfer(8'hFF, 1'b1, q, ak);
		chk_link(q, d1);
		m.stop;
		bus(0, 5'h04, 0, 16'h0090);
		$display("transmit done");
		bus(1, 5'h08, 16'h02C5, 0);
		bus(1, 5'h00, 16'h8400, 0);
		m.start;
		m.xfer(8'hF4, 1'b1, q, ak);
		chk_link({7'h00, ak}, 8'h00);
		m.xfer(8'hC5, 1'b1, q, ak);
		chk_link({7'h00, ak}, 8'h00);
		m.xfer(d1, 1'b1, q, ak);
		chk_link({7'h00, ak}, 8'h00);
		m.start;
		m.xfer(8'hF5, 1'b1, q, ak);
		chk_link({7'h00, ak}, 8'h00);
		bus(1, 5'h0C, {8'h00, ~d2}, 0);
		bus(1, 5'h00, 16'h9400, 0);
		m.xfer(8'hFF, 1'b1, q, ak);
		chk_link(q, ~d2);
		m.stop;
		bus(0, 5'h04, 0, 16'h00B2);
		m.start;
		m.xfer(8'hF2, 1'b1, q, ak);
		chk_link({7'h00, ak}, 8'h01);
		m.stop;
		bus(0, 5'h04, 0, 16'h0092);
		bus(0, 5'h10, 0, {8'h00, d1});
		$display("wide address done");
		finish_test;
	end
endmodule // testbench
